// file: conv_start_bit_pkg.sv
package conv_start_bit_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CONV_START_BIT_OFF_MODE = 8'h00;
  localparam logic [7:0] CONV_START_BIT_OFF_CHAN = 8'h04;
  localparam logic [7:0] CONV_START_BIT_OFF_PFM = 8'h08;
  localparam logic [7:0] CONV_START_BIT_OFF_THR = 8'h0C;
  localparam logic [7:0] CONV_START_BIT_OFF_RESULT = 8'h10;
  localparam logic [7:0] CONV_START_BIT_OFF_STATUS = 8'h14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CONV_START_BIT_START_POS = 7;
  localparam int CONV_START_BIT_ENABLE_POS = 0;
  localparam int CONV_START_BIT_TIME_LSB = 3;
  localparam int CONV_START_BIT_PF_EN_POS = 7;
  localparam int CONV_START_BIT_PF_CM_POS = 6;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONV_START_BIT_MODE_RST = 8'h00;
  localparam logic [2:0] CONV_START_BIT_CHAN_RST = 3'h0;
  localparam logic [7:0] CONV_START_BIT_PFM_RST = 8'h00;
  localparam logic [7:0] CONV_START_BIT_THR_RST = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CONV_START_BIT_CLK_MHZ = 100;
  localparam int CONV_START_BIT_SETTLE_US = 14;
  localparam int CONV_START_BIT_SETTLE_CYC = CONV_START_BIT_SETTLE_US * CONV_START_BIT_CLK_MHZ;
  localparam int CONV_START_BIT_RES_BITS = 10;
  localparam logic [8:0] CONV_START_BIT_CONV_288 = 9'h120;
  localparam logic [8:0] CONV_START_BIT_CONV_240 = 9'h0F0;
  localparam logic [8:0] CONV_START_BIT_CONV_192 = 9'h0C0;
  localparam logic [8:0] CONV_START_BIT_CONV_144 = 9'h090;
  localparam logic [8:0] CONV_START_BIT_CONV_120 = 9'h078;
  localparam logic [8:0] CONV_START_BIT_CONV_96 = 9'h060;
  localparam logic [8:0] CONV_START_BIT_SAMPLE_CYC = 9'h00C;

  typedef enum {CONV_START_BIT_IDLE, CONV_START_BIT_SAMPLE, CONV_START_BIT_CONVERT} conv_start_bit_state_type;
endpackage : conv_start_bit_pkg

// file: conv_start_bit_timebase.sv
`timescale 1ns/10ps
// Conversion time lookup and elapsed-cycle counter
module conv_start_bit_timebase
  import conv_start_bit_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic run, // Conversion in progress
  input wire logic [2:0] time_code, // Conversion time code
  output logic time_ok, // Code is a permitted one
  output logic [8:0] conv_cycles, // Cycles per conversion
  output logic [8:0] elapsed // Cycles since conversion start
);
  always_comb begin
    time_ok = 1'b1;
    case (time_code)
      3'h0: conv_cycles = CONV_START_BIT_CONV_288;
      3'h1: conv_cycles = CONV_START_BIT_CONV_240;
      3'h2: conv_cycles = CONV_START_BIT_CONV_192;
      3'h4: conv_cycles = CONV_START_BIT_CONV_144;
      3'h5: conv_cycles = CONV_START_BIT_CONV_120;
      3'h6: conv_cycles = CONV_START_BIT_CONV_96;
      default: begin
        conv_cycles = CONV_START_BIT_CONV_288;
        time_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed <= 9'h000;
    end else if (!run || elapsed == conv_cycles - 9'h001) begin
      elapsed <= 9'h000;
    end else begin
      elapsed <= elapsed + 9'h001;
    end
  end
endmodule : conv_start_bit_timebase

// file: conv_start_bit_top.sv
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// - Start bit set with power-fail off starts converting the selected channel
// - Normal mode: each end stores result and raises the end interrupt
// - Next conversion starts at once while start bit stays set
// - Write to mode, channel, pfm or threshold aborts and restarts conversion
// - Clearing start bit stops conversion at once; partial result undefined
// - Power-fail mode stores result and compares upper eight bits with threshold
// - Compare mode 0: interrupt only when upper bits >= threshold
// - Compare mode 1: interrupt only when upper bits < threshold
// - Each new result overwrites the result register unconditionally
// - After channel change next interrupt comes one conversion time later
// - Converter stops in standby; software clears start bit first
// - Every conversion yields a 10-bit result
// - Result is left-justified: upper byte eight MSBs, lower byte two LSBs
// - A read coinciding with conversion end completes first
// - Mode or channel write at conversion end wins; no store, no interrupt
// - Only six conversion-time codes are valid; others prohibited
module conv_start_bit_top
  import conv_start_bit_pkg::*;
#(
  parameter int RES_BITS = CONV_START_BIT_RES_BITS // Result width
)(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic standby, // Standby request
  input wire logic comp_in, // Comparator decision from front end
  output logic sample_hold, // Front end in sampling phase
  output logic [2:0] analog_sel, // Selected analog input
  output logic [RES_BITS-1:0] dac_code, // Trial code to tap selector
  output logic conv_end_irq // Conversion end interrupt pulse
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] conv_mode_reg;
  logic [2:0] channel_select_reg;
  logic [7:0] pwrfail_mode_reg;
  logic [7:0] pwrfail_threshold_reg;
  logic [15:0] conv_result_reg;
  logic [RES_BITS-1:0] successive_approx_reg;
  logic [3:0] bit_idx;
  conv_start_bit_state_type state;
  logic comp_meta, comp_sync;
  logic time_ok;
  logic [8:0] conv_cycles, elapsed;
  logic conv_done, step;
  logic [RES_BITS-1:0] next_sar;
  logic first_pending;

  wire conv_start_bit = conv_mode_reg[CONV_START_BIT_START_POS];
  wire conv_enable_bit = conv_mode_reg[CONV_START_BIT_ENABLE_POS];
  wire pwrfail_enable_bit = pwrfail_mode_reg[CONV_START_BIT_PF_EN_POS];
  wire pwrfail_cmp_mode_bit = pwrfail_mode_reg[CONV_START_BIT_PF_CM_POS];
  wire [2:0] conv_time_field = conv_mode_reg[CONV_START_BIT_TIME_LSB+2:CONV_START_BIT_TIME_LSB];
  wire run = state != CONV_START_BIT_IDLE;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire mapped = paddr == CONV_START_BIT_OFF_MODE || paddr == CONV_START_BIT_OFF_CHAN || paddr == CONV_START_BIT_OFF_PFM
    || paddr == CONV_START_BIT_OFF_THR || paddr == CONV_START_BIT_OFF_RESULT || paddr == CONV_START_BIT_OFF_STATUS;
  wire wr_mode = wr && paddr == CONV_START_BIT_OFF_MODE;
  wire wr_chan = wr && paddr == CONV_START_BIT_OFF_CHAN;
  wire wr_pfm = wr && paddr == CONV_START_BIT_OFF_PFM;
  wire wr_thr = wr && paddr == CONV_START_BIT_OFF_THR;
  wire restart = wr_mode || wr_chan || wr_pfm || wr_thr;
  // A write clearing the start bit stops in the same cycle
  wire stop = standby || !conv_start_bit
    || (wr_mode && !pwdata[CONV_START_BIT_START_POS]);

  // One-cycle access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          CONV_START_BIT_OFF_MODE: prdata <= {24'h000000, conv_mode_reg};
          CONV_START_BIT_OFF_CHAN: prdata <= {29'h0000000, channel_select_reg};
          CONV_START_BIT_OFF_PFM: prdata <= {24'h000000, pwrfail_mode_reg[7:6], 6'h00};
          CONV_START_BIT_OFF_THR: prdata <= {24'h000000, pwrfail_threshold_reg};
          CONV_START_BIT_OFF_RESULT: prdata <= {16'h0000, conv_result_reg};
          CONV_START_BIT_OFF_STATUS: prdata <= {29'h0000000, first_pending, time_ok, run};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_mode_reg <= CONV_START_BIT_MODE_RST;
      channel_select_reg <= CONV_START_BIT_CHAN_RST;
      pwrfail_mode_reg <= CONV_START_BIT_PFM_RST;
      pwrfail_threshold_reg <= CONV_START_BIT_THR_RST;
    end else begin
      if (wr_mode) conv_mode_reg <= pwdata[7:0];
      if (wr_chan) channel_select_reg <= pwdata[2:0];
      if (wr_pfm) pwrfail_mode_reg <= {pwdata[7:6], 6'h00};
      if (wr_thr) pwrfail_threshold_reg <= pwdata[7:0];
    end
  end

  // Marks first result after a start without the enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pending <= 1'b0;
    end else if (wr_mode && pwdata[CONV_START_BIT_START_POS] && !conv_start_bit) begin
      first_pending <= !conv_enable_bit && !pwdata[CONV_START_BIT_ENABLE_POS];
    end else if (conv_done) begin
      first_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end

  conv_start_bit_timebase u_timebase (
    .pclk(pclk),
    .presetn(presetn),
    .run(run && !restart),
    .time_code(conv_time_field),
    .time_ok(time_ok),
    .conv_cycles(conv_cycles),
    .elapsed(elapsed)
  );

  // Bit decisions every 8 cycles after sampling; all ten fit the shortest time
  assign step = state == CONV_START_BIT_CONVERT
    && elapsed >= CONV_START_BIT_SAMPLE_CYC
    && ((elapsed - CONV_START_BIT_SAMPLE_CYC) & 9'h007) == 9'h007;
  assign conv_done = run && !restart && !stop
    && elapsed == conv_cycles - 9'h001;

  always_comb begin
    next_sar = successive_approx_reg;
    if (!comp_sync) next_sar[bit_idx] = 1'b0;
    if (bit_idx != 4'h0) next_sar[bit_idx - 4'h1] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CONV_START_BIT_IDLE;
      successive_approx_reg <= '0;
      bit_idx <= 4'h0;
    end else if (stop) begin
      state <= CONV_START_BIT_IDLE;
    end else if (restart || conv_done || state == CONV_START_BIT_IDLE) begin
      state <= CONV_START_BIT_SAMPLE;
      successive_approx_reg <= '0;
      successive_approx_reg[RES_BITS-1] <= 1'b1;
      bit_idx <= 4'(RES_BITS - 1);
    end else if (state == CONV_START_BIT_SAMPLE && elapsed == CONV_START_BIT_SAMPLE_CYC - 9'h001) begin
      state <= CONV_START_BIT_CONVERT;
    end else if (step && bit_idx != 4'hF) begin
      successive_approx_reg <= next_sar;
      bit_idx <= bit_idx - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Result and interrupt
  // ----------------------------------------------------------------
  wire [RES_BITS-1:0] final_sar = successive_approx_reg;
  wire ge_thr = final_sar[RES_BITS-1:RES_BITS-8] >= pwrfail_threshold_reg;
  wire irq_hit = !pwrfail_enable_bit
    || (!pwrfail_cmp_mode_bit && ge_thr)
    || (pwrfail_cmp_mode_bit && !ge_thr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_result_reg <= 16'h0000;
    end else if (conv_done) begin
      conv_result_reg <= {final_sar, {(16 - RES_BITS){1'b0}}};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_end_irq <= 1'b0;
    end else begin
      conv_end_irq <= conv_done && irq_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_hold <= 1'b0;
      analog_sel <= 3'h0;
      dac_code <= '0;
    end else begin
      sample_hold <= !stop && state == CONV_START_BIT_SAMPLE;
      analog_sel <= channel_select_reg;
      dac_code <= successive_approx_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  irq_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_end_irq |=> !conv_end_irq) else $error("irq longer than one cycle");
  write_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> !conv_end_irq && $stable(conv_result_reg))
    else $error("irq or store after register write");
  stop_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_mode && !pwdata[CONV_START_BIT_START_POS]) |=> state == CONV_START_BIT_IDLE ##1 !conv_end_irq)
    else $error("start clear did not stop");
  result_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> conv_result_reg[15:16-RES_BITS] == $past(final_sar))
    else $error("result not stored");
  cmp_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_done && pwrfail_enable_bit && pwrfail_cmp_mode_bit && ge_thr) |=> !conv_end_irq)
    else $error("irq despite >= threshold");
  cmp_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_done && pwrfail_enable_bit && !pwrfail_cmp_mode_bit && ge_thr) |=> conv_end_irq)
    else $error("missing irq at >= threshold");
  normal_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_done && !pwrfail_enable_bit) |=> conv_end_irq)
    else $error("missing normal irq");
  repeat_conv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_done && !restart && !stop) |=> state == CONV_START_BIT_SAMPLE)
    else $error("no back to back conversion");
  result_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_result_reg[15-RES_BITS:0] == '0) else $error("result not left justified");
  start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == CONV_START_BIT_IDLE && !stop) |=> state == CONV_START_BIT_SAMPLE)
    else $error("start ignored");

  normal_cov: cover property (@(posedge pclk) disable iff (!presetn)
    conv_end_irq && !pwrfail_enable_bit);
  pf_cov: cover property (@(posedge pclk) disable iff (!presetn)
    conv_done && pwrfail_enable_bit && !irq_hit);
  restart_cov: cover property (@(posedge pclk) disable iff (!presetn)
    restart && state == CONV_START_BIT_CONVERT);
endmodule : conv_start_bit_top

// file: conv_start_bit_front_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Analog front end: sample-and-hold plus comparator
// ------------------------------------------------------------
module conv_start_bit_front_model (
  input wire logic pclk, // Clock
  input wire logic sample_hold, // Sampling phase from converter
  input wire logic [2:0] analog_sel, // Selected analog input
  input wire logic [9:0] dac_code, // Trial code from converter
  input wire logic [79:0] levels, // Ten-bit level of each input
  output logic comp_in // 1 when held level >= trial
);
  logic [9:0] held = 10'h000;

  // Track the selected input while sampling, hold it afterwards
  always @(posedge pclk) begin
    if (sample_hold === 1'b1) begin
      held <= levels[analog_sel*10 +: 10];
    end
  end

  assign comp_in = (held >= dac_code);
endmodule : conv_start_bit_front_model

// file: test_adc_sequencer_powerfail_compare.sv
`timescale 1ns/10ps
module test_adc_sequencer_powerfail_compare
  import conv_start_bit_pkg::*;
;
  localparam logic [79:0] LEVELS = {10'h3F0, 10'h155, 10'h0C4, 10'h2AA, 10'h2B7, 10'h1E1,
    10'h07F, 10'h301};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic standby = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic comp_in;
  logic sample_hold;
  logic [2:0] analog_sel;
  logic [9:0] dac_code;
  logic conv_end_irq;
  logic prev_irq = 1'b0;
  int cyc = 0;
  int irq_cnt = 0;
  int irq_at = 0;
  int wr_at = 0;
  int mismatches = 0;
  int compares = 0;
  logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
  int cyc_tab [7] = '{288, 240, 192, 144, 120, 96, 288};
  logic pf_cm [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] pf_thr [4] = '{8'h32, 8'hAE, 8'hAD, 8'h31};
  int pf_ch [4] = '{5, 3, 3, 5};
  int pf_n [4] = '{2, 0, 2, 0};

  conv_start_bit_top u_conv_start_bit_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby(standby), .comp_in(comp_in), .sample_hold(sample_hold),
    .analog_sel(analog_sel), .dac_code(dac_code), .conv_end_irq(conv_end_irq));
  conv_start_bit_front_model u_conv_start_bit_front_model (.pclk(pclk), .sample_hold(sample_hold),
    .analog_sel(analog_sel), .dac_code(dac_code), .levels(LEVELS), .comp_in(comp_in));

  // ------------------------------------------------------------
  // Access and checking tasks
  // ------------------------------------------------------------
  always #5 pclk = ~pclk;

  function automatic logic [31:0] res_of(input int c);
    return {16'h0000, LEVELS[c*10 +: 10], 6'h00};
  endfunction : res_of

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    wr_at = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    check(n, rd, e);
  endtask : rchk

  task automatic wait_irq(output int at);
    int n0;
    int k;
    n0 = irq_cnt;
    k = 0;
    while (irq_cnt == n0 && k < 1000) begin
      @(posedge pclk);
      k++;
    end
    check("irq_seen", 32'(irq_cnt != n0), 32'h1);
    at = irq_at;
  endtask : wait_irq

  task automatic quiet(input int n, input int exp);
    int n0;
    n0 = irq_cnt;
    repeat (n) @(posedge pclk);
    check("irq_count", 32'(irq_cnt - n0), 32'(exp));
  endtask : quiet

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    prev_irq <= conv_end_irq;
    if (conv_end_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
      irq_at <= cyc;
      check("irq_pulse", {31'h0, prev_irq}, 32'h0);
    end
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    int a;
    int b;
    logic [31:0] rd;
    logic er;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rchk("reset_value", 8'(4 * i), 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0, rd, er);
    check("unmapped_data", rd, 32'h0);
    check("unmapped_err", {31'h0, er}, 32'h1);
    wr(CONV_START_BIT_OFF_CHAN, 32'h3);
    wr(CONV_START_BIT_OFF_MODE, 32'h31);
    repeat (CONV_START_BIT_SETTLE_CYC) @(posedge pclk);
    wr(CONV_START_BIT_OFF_MODE, 32'hB1);
    wait_irq(a);
    wait_irq(b);
    check("period", 32'(b - a), 32'd96);
    rchk("result", CONV_START_BIT_OFF_RESULT, res_of(3));
    rchk("status", CONV_START_BIT_OFF_STATUS, 32'h3);
    repeat (20) @(posedge pclk);
    wr(CONV_START_BIT_OFF_CHAN, 32'h5);
    a = wr_at;
    wait_irq(b);
    check("restart_time", 32'(b - a >= 96 && b - a <= 98), 32'h1);
    rchk("overwrite", CONV_START_BIT_OFF_RESULT, res_of(5));
    for (int i = 0; i < 7; i++) begin
      wr(CONV_START_BIT_OFF_MODE, {24'h0, 2'b10, codes[i], 3'b001});
      wait_irq(a);
      wait_irq(b);
      check("conv_time", 32'(b - a), 32'(cyc_tab[i]));
      rchk("time_valid", CONV_START_BIT_OFF_STATUS, {30'h0, i < 6, 1'b1});
    end
    wr(CONV_START_BIT_OFF_MODE, 32'hB1);
    repeat (40) @(posedge pclk);
    wr(CONV_START_BIT_OFF_MODE, 32'h31);
    quiet(400, 0);
    rchk("stopped", CONV_START_BIT_OFF_STATUS, 32'h2);
    wr(CONV_START_BIT_OFF_MODE, 32'h30);
    wr(CONV_START_BIT_OFF_MODE, 32'hB0);
    rchk("first_flag", CONV_START_BIT_OFF_STATUS, 32'h7);
    wait_irq(a);
    rchk("first_clear", CONV_START_BIT_OFF_STATUS, 32'h3);
    wr(CONV_START_BIT_OFF_MODE, 32'hB1);
    repeat (40) @(posedge pclk);
    standby <= 1'b1;
    quiet(400, 0);
    standby <= 1'b0;
    wait_irq(a);
    for (int i = 0; i < 4; i++) begin
      wr(CONV_START_BIT_OFF_MODE, 32'h31);
      wr(CONV_START_BIT_OFF_PFM, {24'h0, 1'b1, pf_cm[i], 6'h00});
      wr(CONV_START_BIT_OFF_THR, {24'h0, pf_thr[i]});
      wr(CONV_START_BIT_OFF_CHAN, pf_ch[i]);
      wr(CONV_START_BIT_OFF_MODE, 32'hB1);
      quiet(250, pf_n[i]);
      rchk("pf_result", CONV_START_BIT_OFF_RESULT, res_of(pf_ch[i]));
    end
    wr(CONV_START_BIT_OFF_MODE, 32'h0);
    results();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    results();
  end
endmodule : test_adc_sequencer_powerfail_compare
